// >>> logic/cwb_channel_write.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R01] Two byte buffer sits between channel bus and inbound byte register.
// [R02] Write starts after count load plus transfer and write bits set.
// [R03] Loading the byte counter clears the count-exhausted latch.
// [R04] Buffer-ready is held clear for two cycles after transfer and write set.
// [R05] First request is Data In; buffer-ready clear until byte arrives.
// [R06] Received byte goes to inbound register and sets buffer-ready.
// [R07] With a free entry, the next request is raised at once.
// [R08] Reading inbound register pops; buffer-ready stays if more remain.
// [R09] Counter decrements per byte; zero blocks new requests until reload.
// [R10] Both entries full blocks further requests until one is consumed.
// [R11] Requests alternate Data In and Service In.
// [R12] Count-exhausted is interrupt bit 0; software then clears control.
// [R13] Command Out truncates: no decrement, no buffer-ready, flag bits set.
// [R14] Software signals overrun with stop strobe and error bit 3.
// [R15] Stop lets the current request finish and blocks new ones.
// [R16] Stop with no request active halts the transfer at once.
// [R17] After stop, queue-empty sets once the current sequence finishes.
// [R18] Address Out halt is shown; software clears control bits.
// [R19] Suppress bit 5 holds new requests off while Suppress Out is high.
// [R20] Buffer-ready means at least one entry is full during writes.
// [R21] Queue-empty means counter zero (or stopped and idle).
// [R22] Channel interrupt from selection or operational with halt/truncate.
// [R23] Byte counter is a sixteen bit loadable down counter.
// [R24] A byte counts only when In meets the matching Out tag.
// [R25] Exhausted latch sets on a handshake with count one, synchronous.
// [R26] Counter moves to or from working register only with transfer off.
// [R27] Channel tags pass two flip-flops before any logic reads them.
// [R28] Reset clears control bits, empties buffer and drops request tags.
module cwb_channel_write (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   // AXI4-Lite slave
   input  wire logic [7:0]           s_awaddr,
   input  wire logic                 s_awvalid,
   output logic                      s_awready,
   input  wire logic [31:0]          s_wdata,
   input  wire logic [3:0]           s_wstrb,
   input  wire logic                 s_wvalid,
   output logic                      s_wready,
   output logic [1:0]                s_bresp,
   output logic                      s_bvalid,
   input  wire logic                 s_bready,
   input  wire logic [7:0]           s_araddr,
   input  wire logic                 s_arvalid,
   output logic                      s_arready,
   output logic [31:0]               s_rdata,
   output logic [1:0]                s_rresp,
   output logic                      s_rvalid,
   input  wire logic                 s_rready,
   // Channel
   input  wire cwb_pkg::cwb_tags_in_t tagsIn,
   input  wire logic [7:0]           busOut,
   output logic                      dataIn,
   output logic                      serviceIn
);
   import cwb_pkg::*;

   cwb_tags_in_t syncA_q;
   cwb_tags_in_t tags_q;
   logic [7:0]   busA_q;
   logic [7:0]   bus_q;
   cwb_tags_in_t tagsPrev_q;

   // Tags and bus are asynchronous
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncA_q    <= '0;
         tags_q     <= '0;
         tagsPrev_q <= '0;
         busA_q     <= 8'h00;
         bus_q      <= 8'h00;
      end else begin
         syncA_q    <= tagsIn; // [R27]
         tags_q     <= syncA_q; // [R27]
         tagsPrev_q <= tags_q;
         busA_q     <= busOut;
         bus_q      <= busA_q;
      end
   end

   logic        xfer_q, write_q, supp_q;
   logic [15:0] count_q;
   logic [15:0] work_q;
   logic        exhaust_q, cmdOut_q, overrun_q, stop_q, chanInt_q;
   logic [7:0]  buf_q [2];
   logic        rdPtr_q, wrPtr_q;
   logic [1:0]  fill_q;
   logic        useSvc_q;
   logic        enPrev_q, armed_q;
   cwb_state_t  state_q;
   logic        reqTag_q;

   // Bus handshakes
   logic awHeld_q, wHeld_q;
   logic [7:0]  awAddr_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;
   logic doWrite, doRead;
   assign s_awready = !awHeld_q && !s_bvalid;
   assign s_wready  = !wHeld_q && !s_bvalid;
   assign doWrite   = awHeld_q && wHeld_q && !s_bvalid;
   assign s_arready = !s_rvalid;
   assign doRead    = s_arvalid && s_arready;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q  <= 32'h0;
         wStrb_q  <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp  <= RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_wdata;
            wStrb_q <= s_wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            s_bvalid <= 1'b1;
            case (awAddr_q)
               ADDR_CTRL, ADDR_COUNT, ADDR_ERR, ADDR_STOP, ADDR_WORK:
                  s_bresp <= RESP_OKAY;
               default: s_bresp <= RESP_SLVERR;
            endcase
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   logic wrCtrl, wrCount, wrErr, wrStop, wrWork, rdData;
   assign wrCtrl  = doWrite && awAddr_q == ADDR_CTRL && wStrb_q[0];
   assign wrCount = doWrite && awAddr_q == ADDR_COUNT && !xfer_q; // [R26]
   assign wrErr   = doWrite && awAddr_q == ADDR_ERR && wStrb_q[0];
   assign wrStop  = doWrite && awAddr_q == ADDR_STOP;
   assign wrWork  = doWrite && awAddr_q == ADDR_WORK;
   assign rdData  = doRead && s_araddr == ADDR_DATA;

   // Channel handshake on synchronised tags
   logic dataAck, svcAck, cmdAck, byteDone, active, bufRdy, qEmpty, pop;
   assign active   = xfer_q && write_q; // [R02]
   assign dataAck  = dataIn && tags_q.dataOut && !tagsPrev_q.dataOut;
   assign svcAck   = serviceIn && tags_q.serviceOut
                     && !tagsPrev_q.serviceOut;
   assign byteDone = dataAck || svcAck; // [R24]
   assign cmdAck   = (dataIn || serviceIn) && tags_q.commandOut
                     && !tagsPrev_q.commandOut; // [R13]
   assign bufRdy   = armed_q && fill_q != 2'd0; // [R20]
   assign pop      = rdData && fill_q != 2'd0; // [R08]
   assign qEmpty   = count_q == COUNT_RESET
                     || (stop_q && state_q != CWB_REQ); // [R21] [R17]

   logic canReq;
   assign canReq = active && !exhaust_q && count_q != COUNT_RESET // [R09]
                   && (fill_q != 2'd2 || pop) // [R10]
                   && !stop_q // [R15]
                   && !cmdOut_q // [R13]
                   && !(supp_q && tags_q.suppressOut); // [R19]

   // Control, counter and stop
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         xfer_q  <= 1'b0; // [R28]
         write_q <= 1'b0;
         supp_q  <= 1'b0;
      end else if (wrCtrl) begin
         xfer_q  <= wData_q[CTRL_XFER];
         write_q <= wData_q[CTRL_WRITE];
         supp_q  <= wData_q[CTRL_SUPP];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= COUNT_RESET;
         work_q  <= COUNT_RESET;
      end else begin
         if (wrWork) work_q <= wData_q[15:0];
         if (wrCount) begin
            count_q <= wData_q[15:0];
         end else if (byteDone && count_q != COUNT_RESET) begin
            count_q <= count_q - COUNT_ONE; // [R09] [R23]
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         exhaust_q <= 1'b0;
      end else if (byteDone && count_q == COUNT_ONE) begin
         exhaust_q <= 1'b1; // [R25] [R12]
      end else if (wrCount) begin
         exhaust_q <= 1'b0; // [R03]
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stop_q    <= 1'b0;
         overrun_q <= 1'b0;
         cmdOut_q  <= 1'b0;
         chanInt_q <= 1'b0;
      end else begin
         if (wrStop) stop_q <= 1'b1; // [R14] [R16]
         else if (!active) stop_q <= 1'b0;
         if (wrErr) overrun_q <= wData_q[ERR_OVERRUN]; // [R14]
         if (cmdAck) cmdOut_q <= 1'b1; // [R13]
         else if (!active) cmdOut_q <= 1'b0;
         chanInt_q <= (tags_q.initialSel && !tags_q.shortBusy
                       && !tags_q.operationalIn)
                      || (tags_q.operationalIn
                          && (tags_q.addressOut || cmdOut_q)); // [R22] [R18]
      end
   end

   // Buffer-ready held off for the first two cycles after enabling
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         enPrev_q <= 1'b0;
         armed_q  <= 1'b0;
      end else begin
         enPrev_q <= active;
         armed_q  <= active && enPrev_q; // [R04]
      end
   end

   // Two entry byte queue
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
         rdPtr_q  <= 1'b0;
         wrPtr_q  <= 1'b0;
         fill_q   <= 2'd0; // [R28]
      end else if (!active) begin
         rdPtr_q <= 1'b0;
         wrPtr_q <= 1'b0;
         fill_q  <= 2'd0;
      end else begin
         if (byteDone) begin
            buf_q[wrPtr_q] <= bus_q; // [R01] [R06]
            wrPtr_q        <= !wrPtr_q;
         end
         if (pop) rdPtr_q <= !rdPtr_q;
         fill_q <= fill_q + {1'b0, byteDone} - {1'b0, pop};
      end
   end

   // Request sequencer; one sequence is a tag raised until Out answers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q  <= CWB_IDLE;
         reqTag_q <= 1'b0;
         useSvc_q <= 1'b0;
      end else begin
         case (state_q)
            CWB_IDLE: begin
               if (!active) useSvc_q <= 1'b0; // [R05]
               if (canReq && !tags_q.dataOut && !tags_q.serviceOut) begin
                  reqTag_q <= 1'b1; // [R07]
                  state_q  <= CWB_REQ;
               end
            end
            CWB_REQ: begin
               if (byteDone || cmdAck || !active) begin
                  reqTag_q <= 1'b0; // [R15]
                  if (byteDone) useSvc_q <= !useSvc_q; // [R11]
                  state_q  <= CWB_DONE;
               end
            end
            CWB_DONE: begin
               if (!tags_q.dataOut && !tags_q.serviceOut) begin
                  state_q <= CWB_IDLE;
               end
            end
            default: state_q <= CWB_IDLE;
         endcase
      end
   end

   assign dataIn    = reqTag_q && !useSvc_q;
   assign serviceIn = reqTag_q && useSvc_q;

   // Read data
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0;
         s_rresp  <= RESP_OKAY;
      end else if (doRead) begin
         s_rvalid <= 1'b1;
         s_rresp  <= RESP_OKAY;
         s_rdata  <= 32'h0;
         case (s_araddr)
            ADDR_CTRL: begin
               s_rdata[CTRL_XFER]  <= xfer_q;
               s_rdata[CTRL_WRITE] <= write_q;
               s_rdata[CTRL_SUPP]  <= supp_q;
            end
            ADDR_COUNT: s_rdata[15:0] <= count_q;
            ADDR_DATA:  s_rdata[7:0] <= active ? buf_q[rdPtr_q] : bus_q;
            ADDR_INTR: begin
               s_rdata[INTR_EXHAUST] <= exhaust_q;
               s_rdata[INTR_CHANINT] <= chanInt_q;
            end
            // Sticky, so a short Command Out pulse is not missed
            ADDR_FLAG: s_rdata[FLAG_CMDOUT] <= cmdOut_q; // [R13]
            ADDR_ERR:  s_rdata[ERR_OVERRUN] <= overrun_q;
            ADDR_STAT: begin
               s_rdata[STAT_BUFRDY]  <= bufRdy;
               s_rdata[STAT_QEMPTY]  <= qEmpty;
               s_rdata[STAT_STOPPED] <= stop_q;
            end
            ADDR_WORK: s_rdata[15:0] <= xfer_q ? work_q : count_q; // [R26]
            ADDR_STOP: s_rdata <= 32'h0;
            default: s_rresp <= RESP_SLVERR;
         endcase
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

   // Checks
   a_count_step: assert property (@(posedge sys_clk) disable iff (!nrst)
      byteDone && !wrCount && count_q != COUNT_RESET
      |=> count_q == $past(count_q) - COUNT_ONE) // [R09]
      else $error("count did not step");
   a_exhaust_set: assert property (@(posedge sys_clk) disable iff (!nrst)
      byteDone && count_q == COUNT_ONE |=> exhaust_q) // [R25]
      else $error("exhaust latch missed");
   a_load_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
      wrCount && !(byteDone && count_q == COUNT_ONE) |=> !exhaust_q) // [R03]
      else $error("load did not clear latch");
   a_no_req_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_q == CWB_IDLE && count_q == COUNT_RESET |=> !reqTag_q) // [R09]
      else $error("request at zero count");
   a_full_block: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_q == CWB_IDLE && fill_q == 2'd2 && !pop |=> !reqTag_q) // [R10]
      else $error("request with full buffer");
   a_rdy_delay: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(active) |-> !bufRdy ##1 !bufRdy) // [R04]
      else $error("ready too early");
   a_stop_block: assert property (@(posedge sys_clk) disable iff (!nrst)
      stop_q && state_q == CWB_IDLE |=> !reqTag_q) // [R15]
      else $error("request after stop");
   a_trunc_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      cmdAck && !byteDone && !wrCount |=> count_q == $past(count_q)) // [R13]
      else $error("truncation moved count");
   a_supp_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      state_q == CWB_IDLE && supp_q && tags_q.suppressOut
      |=> !reqTag_q) // [R19]
      else $error("request under suppress");
   a_tags_excl: assert property (@(posedge sys_clk) disable iff (!nrst)
      !(dataIn && serviceIn)) // [R11]
      else $error("both request tags high");
   a_trunc_block: assert property (@(posedge sys_clk) disable iff (!nrst)
      cmdOut_q && state_q == CWB_IDLE |=> !reqTag_q) // [R13]
      else $error("request after truncation");
   c_byte: cover property (@(posedge sys_clk) disable iff (!nrst)
      byteDone && count_q == COUNT_ONE);
   c_full: cover property (@(posedge sys_clk) disable iff (!nrst)
      fill_q == 2'd2);
   c_trunc: cover property (@(posedge sys_clk) disable iff (!nrst) cmdAck);
   c_stop: cover property (@(posedge sys_clk) disable iff (!nrst)
      stop_q && qEmpty);
endmodule : cwb_channel_write
`default_nettype wire

// >>> logic/cwb_pkg.sv
package cwb_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00; // channel_control_register
   localparam logic [7:0] ADDR_COUNT  = 8'h04; // byte_count_register
   localparam logic [7:0] ADDR_DATA   = 8'h08; // inbound_byte_register
   localparam logic [7:0] ADDR_INTR   = 8'h0c; // interrupt bits
   localparam logic [7:0] ADDR_FLAG   = 8'h10; // channel_flag_register
   localparam logic [7:0] ADDR_ERR    = 8'h14; // error_status_register
   localparam logic [7:0] ADDR_STAT   = 8'h18; // branch conditions
   localparam logic [7:0] ADDR_STOP   = 8'h1c; // transfer-stop strobe
   localparam logic [7:0] ADDR_WORK   = 8'h20; // counter_working_register
   // Field positions
   localparam int CTRL_XFER     = 0;
   localparam int CTRL_WRITE    = 1;
   localparam int CTRL_SUPP     = 5;
   localparam int INTR_EXHAUST  = 0;
   localparam int INTR_CHANINT  = 5;
   localparam int FLAG_CMDOUT   = 4;
   localparam int ERR_OVERRUN   = 3;
   localparam int STAT_BUFRDY   = 0;
   localparam int STAT_QEMPTY   = 1;
   localparam int STAT_STOPPED  = 2;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ONE   = 16'h0001;

   // Channel tags coming in
   typedef struct packed {
      logic serviceOut;
      logic dataOut;
      logic commandOut;
      logic addressOut;
      logic suppressOut;
      logic operationalIn;
      logic initialSel;
      logic shortBusy;
   } cwb_tags_in_t;

   typedef enum logic [1:0] {
      CWB_IDLE = 2'b00,
      CWB_REQ  = 2'b01,
      CWB_DONE = 2'b11
   } cwb_state_t;
endpackage : cwb_pkg

// >>> testbench/cwb_channel_model.sv
`timescale 1ns/10ps
`default_nettype none
module cwb_channel_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Requests from the block, test controls
   input  wire logic       dataIn,
   input  wire logic       serviceIn,
   input  wire logic       trunc,
   input  wire logic [3:0] dly,
   // Answers toward the block, count of bytes sent for the test
   output logic            svcOut,
   output logic            datOut,
   output logic            cmdOut,
   output logic [7:0]      busOut,
   output logic [7:0]      sent
);
   logic [3:0] waitQ;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         waitQ  <= 4'h0;
         svcOut <= 1'b0;
         datOut <= 1'b0;
         cmdOut <= 1'b0;
         busOut <= 8'h00;
         sent   <= 8'h00;
      end else if (svcOut || datOut || cmdOut) begin
         // Hold the answer until the request tag drops
         if (!dataIn && !serviceIn) begin
            svcOut <= 1'b0;
            datOut <= 1'b0;
            cmdOut <= 1'b0;
            busOut <= ~busOut; // Stale byte must not look valid
         end
      end else if (dataIn || serviceIn) begin
         if (waitQ != dly) begin
            waitQ <= waitQ + 4'h1;
         end else begin
            waitQ  <= 4'h0;
            cmdOut <= trunc;
            datOut <= dataIn && !trunc;
            svcOut <= serviceIn && !trunc;
            busOut <= 8'ha0 + sent;
            sent   <= sent + {7'h0, !trunc};
         end
      end
   end
endmodule // cwb_channel_model
`default_nettype wire

// >>> testbench/test_channel_write_buffered_transfer.sv
`timescale 1ns/10ps
`default_nettype none
module test_channel_write_buffered_transfer;
   import cwb_pkg::*;
   localparam int LIMIT = 20000;
   logic         sys_clk, nrst, s_awvalid, s_awready, s_wvalid, s_wready;
   logic         s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
   logic [7:0]   s_awaddr, s_araddr, busOut, sent;
   logic [31:0]  s_wdata, s_rdata, d;
   logic [3:0]   s_wstrb, dly;
   logic [1:0]   s_bresp, s_rresp, resp;
   logic         dataIn, serviceIn, svcOut, datOut, cmdOut, trunc;
   logic         addrOut, supOut, opIn, iniSel, shBusy;
   cwb_tags_in_t tags;
   int           num_errors, n_checks, cycles;
   assign tags = '{svcOut, datOut, cmdOut, addrOut, supOut, opIn, iniSel,
                   shBusy};
   cwb_channel_write DUT (.sys_clk, .nrst, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
      .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
      .s_rvalid, .s_rready, .tagsIn(tags), .busOut, .dataIn, .serviceIn);
   cwb_channel_model chan (.sys_clk, .nrst, .dataIn, .serviceIn, .trunc,
      .dly, .svcOut, .datOut, .cmdOut, .busOut, .sent);
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic test_done;
      if (num_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         num_errors++;
         test_done;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit got;
      got = 0;
      s_awaddr <= a;
      s_wdata <= v;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      while (!got) begin
         @(posedge sys_clk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
         if (s_bvalid === 1'b1) begin
            resp = s_bresp;
            got = 1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      bit got;
      got = 0;
      s_araddr <= a;
      s_arvalid <= 1'b1;
      while (!got) begin
         @(posedge sys_clk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
         if (s_rvalid === 1'b1) begin
            d = s_rdata;
            resp = s_rresp;
            got = 1;
         end
      end
   endtask
   task automatic rst;
      nrst <= 1'b0;
      {dly, trunc, addrOut, supOut, opIn, iniSel, shBusy} <= '0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
   endtask
   task automatic sIdle;
      rst;
      chk({30'h0, serviceIn, dataIn}, 32'h0);
      rd(ADDR_CTRL);
      chk(d, 32'h0);
      rd(ADDR_STAT);
      chk(d & 32'h3, 32'h2);
      rd(8'h24);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(8'h24, 32'h0);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(ADDR_ERR, 32'h0);
      chk({30'h0, resp}, {30'h0, RESP_OKAY});
   endtask
   task automatic sBasic;
      rst;
      dly <= 4'h4;
      wr(ADDR_COUNT, 32'h3);
      wr(ADDR_CTRL, 32'h3);
      while (dataIn !== 1'b1) @(posedge sys_clk);
      chk({31'h0, serviceIn}, 32'h0);
      rd(ADDR_STAT);
      chk(d & 32'h1, 32'h0);
      while (serviceIn !== 1'b1) @(posedge sys_clk);
      chk({31'h0, dataIn}, 32'h0);
      while (sent < 8'd2) @(posedge sys_clk);
      repeat (12) @(posedge sys_clk);
      chk({30'h0, serviceIn, dataIn}, 32'h0);
      rd(ADDR_DATA);
      chk(d, 32'ha0);
      rd(ADDR_STAT);
      chk(d & 32'h1, 32'h1);
      rd(ADDR_DATA);
      chk(d, 32'ha1);
      while (sent < 8'd3) @(posedge sys_clk);
      repeat (6) @(posedge sys_clk);
      rd(ADDR_STAT);
      chk(d & 32'h1, 32'h1);
      rd(ADDR_DATA);
      chk(d, 32'ha2);
      rd(ADDR_STAT);
      chk(d & 32'h3, 32'h2);
      rd(ADDR_INTR);
      chk(d & 32'h1, 32'h1);
      repeat (10) @(posedge sys_clk);
      chk({30'h0, serviceIn, dataIn}, 32'h0);
      wr(ADDR_COUNT, 32'h5);
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_COUNT);
      chk(d, 32'h0);
      wr(ADDR_COUNT, 32'h1);
      rd(ADDR_INTR);
      chk(d & 32'h1, 32'h0);
      dly <= 4'h9;
      wr(ADDR_CTRL, 32'h3);
      while (sent < 8'd4) @(posedge sys_clk);
      repeat (6) @(posedge sys_clk);
      rd(ADDR_DATA);
      chk(d, 32'ha3);
   endtask
   task automatic sTrunc;
      rst;
      trunc <= 1'b1;
      opIn <= 1'b1;
      wr(ADDR_COUNT, 32'h2);
      wr(ADDR_CTRL, 32'h3);
      while (cmdOut !== 1'b1) @(posedge sys_clk);
      repeat (6) @(posedge sys_clk);
      rd(ADDR_FLAG);
      chk(d & 32'h10, 32'h10);
      rd(ADDR_INTR);
      chk(d & 32'h20, 32'h20);
      rd(ADDR_STAT);
      chk(d & 32'h1, 32'h0);
      chk({30'h0, serviceIn, dataIn}, 32'h0);
      wr(ADDR_CTRL, 32'h0);
      rd(ADDR_COUNT);
      chk(d, 32'h2);
   endtask
   task automatic sStop;
      rst;
      dly <= 4'hc;
      wr(ADDR_COUNT, 32'h4);
      wr(ADDR_CTRL, 32'h3);
      while (dataIn !== 1'b1) @(posedge sys_clk);
      wr(ADDR_STOP, 32'h1);
      while (sent < 8'd1) @(posedge sys_clk);
      repeat (12) @(posedge sys_clk);
      chk({30'h0, serviceIn, dataIn}, 32'h0);
      rd(ADDR_STAT);
      chk(d & 32'h6, 32'h6);
      rd(ADDR_DATA);
      chk(d, 32'ha0);
      wr(ADDR_ERR, 32'h8);
      rd(ADDR_ERR);
      chk(d & 32'h8, 32'h8);
   endtask
   task automatic sSupp(input bit stop);
      rst;
      supOut <= 1'b1;
      // Slow answer keeps the resumed request standing at the check
      dly <= 4'hf;
      wr(ADDR_COUNT, 32'h2);
      wr(ADDR_CTRL, 32'h23);
      repeat (10) @(posedge sys_clk);
      chk({30'h0, serviceIn, dataIn}, 32'h0);
      if (stop) wr(ADDR_STOP, 32'h1);
      supOut <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk({31'h0, dataIn}, {31'h0, !stop});
   endtask
   task automatic sInt;
      rst;
      iniSel <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rd(ADDR_INTR);
      chk(d & 32'h20, 32'h20);
      shBusy <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rd(ADDR_INTR);
      chk(d & 32'h20, 32'h0);
      {iniSel, shBusy, opIn, addrOut} <= 4'h3;
      repeat (5) @(posedge sys_clk);
      rd(ADDR_INTR);
      chk(d & 32'h20, 32'h20);
   endtask
   initial begin
      {s_awvalid, s_wvalid, s_arvalid, s_awaddr, s_araddr, s_wdata} = '0;
      {s_bready, s_rready, s_wstrb} = 6'h3f;
      {num_errors, n_checks, cycles} = '0;
      sIdle;
      sBasic;
      sTrunc;
      sStop;
      sSupp(1'b0);
      sSupp(1'b1);
      sInt;
      test_done;
   end
endmodule // test_channel_write_buffered_transfer
`default_nettype wire
